// File: usf_line_partner.sv
`timescale 1ns/1ns
module usf_line_partner (
  input wire logic core_clk_in, // bus clock
  input wire logic stall_in, // keep shifter busy
  input wire logic tx_load_in, // word taken
  output logic tx_shift_ready_out, // shifter free
  output logic tx_frame_done_out, // pulse: frame sent
  output logic rx_valid_out, // pulse: word complete
  output logic [8:0] rx_word_out, // received word
  output logic [2:0] rx_err_out, // noise, framing, parity
  output logic rx_idle_out, // pulse: idle line
  output logic line_break_out // pulse: break
);
  int busy_cnt;
  initial begin
    busy_cnt = 0;
    tx_frame_done_out = 1'b0;
    rx_valid_out = 1'b0;
    rx_word_out = 9'h1FF;
    rx_err_out = 3'h0;
    rx_idle_out = 1'b0;
    line_break_out = 1'b0;
  end
  ////////////////////////////////////////
  // shifter stays busy for the whole frame, not just the handover
  always_comb tx_shift_ready_out = !stall_in && (busy_cnt == 0);
  always @(posedge core_clk_in) begin
    tx_frame_done_out <= 1'b0;
    if (tx_load_in) begin
      busy_cnt <= 8;
    end else if (busy_cnt > 0) begin
      busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) tx_frame_done_out <= 1'b1;
    end
  end
  // qualifiers go to the inverse once valid drops, never a stale copy
  task send(input logic [8:0] w, input logic [2:0] e);
    @(posedge core_clk_in);
    rx_valid_out <= 1'b1;
    rx_word_out <= w;
    rx_err_out <= e;
    @(posedge core_clk_in);
    rx_valid_out <= 1'b0;
    rx_word_out <= ~w;
    rx_err_out <= ~e;
  endtask : send
  task pulse_line(input logic brk);
    @(posedge core_clk_in);
    if (brk) line_break_out <= 1'b1;
    else rx_idle_out <= 1'b1;
    @(posedge core_clk_in);
    line_break_out <= 1'b0;
    rx_idle_out <= 1'b0;
  endtask : pulse_line
endmodule : usf_line_partner

// File: usf_pkg.sv
package usf_pkg;

  // register word offsets (byte addresses)
  localparam logic [7:0] USF_STATUS_OFS = 8'h00;
  localparam logic [7:0] USF_DATA_OFS = 8'h04;
  localparam logic [7:0] USF_CTRL_OFS = 8'h08;

  // line_status_flags field positions
  localparam int USF_PARITY_BIT = 0;
  localparam int USF_FRAMING_BIT = 1;
  localparam int USF_NOISE_BIT = 2;
  localparam int USF_OVERRUN_BIT = 3;
  localparam int USF_IDLE_BIT = 4;
  localparam int USF_RX_FULL_BIT = 5;
  localparam int USF_TX_DONE_BIT = 6;
  localparam int USF_TX_EMPTY_BIT = 7;
  localparam int USF_BREAK_BIT = 8;
  localparam int USF_CTS_BIT = 9;
  localparam int USF_STATUS_W = 10;

  // control register field positions
  localparam int USF_C_FLOW_EN = 0;
  localparam int USF_C_CTS_IE = 1;
  localparam int USF_C_BREAK_IE = 2;
  localparam int USF_C_TX_EMPTY_IE = 3;
  localparam int USF_C_TX_DONE_IE = 4;
  localparam int USF_C_RX_FULL_IE = 5;
  localparam int USF_C_IDLE_IE = 6;
  localparam int USF_C_ERR_IE = 7;
  localparam int USF_C_PARITY_IE = 8;
  localparam int USF_C_MULTIBUF = 9;
  localparam int USF_C_RX_EN = 10;
  localparam int USF_CTRL_W = 11;

  // data field width and reset values
  localparam int USF_DATA_W = 9;
  localparam logic [USF_STATUS_W-1:0] USF_STATUS_RST = 10'h0C0;
  localparam logic [USF_CTRL_W-1:0] USF_CTRL_RST = 11'h000;
  localparam logic [USF_DATA_W-1:0] USF_DATA_RST = 9'h000;

  // clear-to-send pin idles high (inactive)
  localparam logic USF_CTS_IDLE = 1'b1;

endpackage : usf_pkg

// File: usf_status_flags.sv
// Overview of operation
// - clear-to-send edge sets change flag when enabled
// - line break sets break flag, interrupt if enabled
// - tx empty set on shifter load, resets high
// - data write clears tx empty; interrupts while set
// - tx complete set after frame with empty holding
// - tx complete cleared by status-then-write or zero
// - tx complete interrupts while set and enabled
// - rx not empty set on word arrival, resets low
// - rx not empty cleared by data access or zero
// - rx interrupt enable covers rx and overrun
// - idle sets flag; status-then-data read clears it
// - idle rearmed only by newly received word
// - overrun set when word arrives while unread
// - overrun keeps unread holding data intact
// - multibuffer error enable interrupts on overrun
// - noise flag set on noisy frame, read-sequence clear
// - noise interrupts only through multibuffer error enable
// - framing error set, multibuffer interrupt, sequence clear
// - parity error in receive mode, enable, sequence clear
// - one data address, two holding registers
`timescale 1ns/1ns
module usf_status_flags
  import usf_pkg::*;
#(
  parameter int DATA_W = USF_DATA_W
) (
  input wire logic core_clk_in, // peripheral bus clock
  input wire logic sys_rst_in, // synchronous reset, active high
  input wire logic [7:0] reg_addr_in, // register byte address
  input wire logic [31:0] reg_wdata_in, // register write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  output logic [31:0] reg_rdata_out, // read data, one cycle after strobe
  input wire logic clear_to_send_input_n_in, // modem pin, active low
  input wire logic tx_shift_ready_in, // shifter can take a word
  input wire logic tx_frame_done_in, // pulse: data frame left the line
  output logic tx_load_out, // pulse: holding word handed over
  output logic [DATA_W-1:0] tx_data_out, // word handed to shifter
  input wire logic rx_word_valid_in, // pulse: shift register complete
  input wire logic [DATA_W-1:0] rx_word_in, // completed received word
  input wire logic rx_noise_in, // noise seen in that frame
  input wire logic rx_frame_err_in, // framing error in that frame
  input wire logic rx_parity_err_in, // parity mismatch in that frame
  input wire logic rx_idle_in, // pulse: idle line detected
  input wire logic line_break_in, // pulse: line break detected
  output logic irq_out // combined interrupt request
);

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  // strobes qualified by address; unmapped accesses fall through
  wire logic status_wr = reg_wr_in && (reg_addr_in == USF_STATUS_OFS);
  wire logic status_rd = reg_rd_in && (reg_addr_in == USF_STATUS_OFS);
  wire logic data_wr = reg_wr_in && (reg_addr_in == USF_DATA_OFS);
  wire logic data_rd = reg_rd_in && (reg_addr_in == USF_DATA_OFS);
  wire logic ctrl_wr = reg_wr_in && (reg_addr_in == USF_CTRL_OFS);
  wire logic ctrl_rd = reg_rd_in && (reg_addr_in == USF_CTRL_OFS);

  // write-zero-to-clear: a 1 written leaves the flag alone
  function automatic logic zero_clear(input logic [31:0] wd, input int pos);
    zero_clear = !wd[pos];
  endfunction : zero_clear

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [USF_CTRL_W-1:0] ctrl_reg;

  // enables and mode bits, plain read/write
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= USF_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_reg <= reg_wdata_in[USF_CTRL_W-1:0];
    end
  end

  // enable and mode bits picked out by name
  wire logic flow_handshake_enable = ctrl_reg[USF_C_FLOW_EN];
  wire logic handshake_change_irq_enable = ctrl_reg[USF_C_CTS_IE];
  wire logic line_break_irq_enable = ctrl_reg[USF_C_BREAK_IE];
  wire logic tx_holding_empty_irq_enable = ctrl_reg[USF_C_TX_EMPTY_IE];
  wire logic tx_complete_irq_enable = ctrl_reg[USF_C_TX_DONE_IE];
  wire logic rx_not_empty_irq_enable = ctrl_reg[USF_C_RX_FULL_IE];
  wire logic idle_line_irq_enable = ctrl_reg[USF_C_IDLE_IE];
  wire logic error_irq_enable = ctrl_reg[USF_C_ERR_IE];
  wire logic parity_irq_enable = ctrl_reg[USF_C_PARITY_IE];
  wire logic multibuffer_mode = ctrl_reg[USF_C_MULTIBUF];
  wire logic receiver_enable = ctrl_reg[USF_C_RX_EN];

  ////////////////////////////////////////////////////////////////////////////
  // status-read memory for the read/write clear sequences

  logic status_seen_reg;

  // armed by a status read, spent by the next data access
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status_seen_reg <= 1'b0;
    end else if (status_rd) begin
      status_seen_reg <= 1'b1;
    end else if (data_rd || data_wr) begin
      status_seen_reg <= 1'b0;
    end
  end

  // a sequence only counts after a completed status read
  wire logic seq_read_clear = data_rd && status_seen_reg;
  wire logic seq_write_clear = data_wr && status_seen_reg;

  ////////////////////////////////////////////////////////////////////////////
  // clear-to-send pin synchroniser and change detect

  logic cts_meta_reg;
  logic cts_sync_reg;
  logic cts_last_reg;

  // pin is asynchronous: two flops before anything looks at it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cts_meta_reg <= USF_CTS_IDLE;
      cts_sync_reg <= USF_CTS_IDLE;
      cts_last_reg <= USF_CTS_IDLE;
    end else begin
      cts_meta_reg <= clear_to_send_input_n_in;
      cts_sync_reg <= cts_meta_reg;
      cts_last_reg <= cts_sync_reg;
    end
  end

  // either edge counts, only with flow control on
  wire logic cts_change = flow_handshake_enable && (cts_sync_reg != cts_last_reg);

  ////////////////////////////////////////////////////////////////////////////
  // status flags

  logic cts_flag_reg;
  logic line_break_flag_reg;
  logic tx_holding_empty_reg;
  logic tx_complete_flag_reg;
  logic rx_not_empty_reg;
  logic idle_flag_reg;
  logic idle_armed_reg;
  logic overrun_flag_reg;
  logic noise_flag_reg;
  logic framing_error_flag_reg;
  logic parity_error_flag_reg;

  // holding word moves to the shifter when full and shifter free
  wire logic tx_handover = !tx_holding_empty_reg && tx_shift_ready_in;
  // a new word lands only if the previous one was taken
  wire logic rx_accept = rx_word_valid_in && !rx_not_empty_reg;
  wire logic rx_overrun = rx_word_valid_in && rx_not_empty_reg;
  wire logic idle_set = rx_idle_in && idle_armed_reg;

  // modem change: hardware set wins over software write-zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cts_flag_reg <= 1'b0;
    end else if (cts_change) begin
      cts_flag_reg <= 1'b1;
    end else if (status_wr && zero_clear(reg_wdata_in, USF_CTS_BIT)) begin
      cts_flag_reg <= 1'b0;
    end
  end

  // line break flag, software cleared by writing zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      line_break_flag_reg <= 1'b0;
    end else if (line_break_in) begin
      line_break_flag_reg <= 1'b1;
    end else if (status_wr && zero_clear(reg_wdata_in, USF_BREAK_BIT)) begin
      line_break_flag_reg <= 1'b0;
    end
  end

  // tx empty is read-only; a write that meets a handover queues a fresh
  // word, so here the clear must win over the set
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_holding_empty_reg <= 1'b1;
    end else if (data_wr) begin
      tx_holding_empty_reg <= 1'b0;
    end else if (tx_handover) begin
      tx_holding_empty_reg <= 1'b1;
    end
  end

  // empty holding seen in this cycle or about to be
  wire logic tx_empty_now = (tx_holding_empty_reg || tx_handover) && !data_wr;

  // tx complete: set wins over both clear routes
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_complete_flag_reg <= 1'b1;
    end else if (tx_frame_done_in && tx_empty_now) begin
      tx_complete_flag_reg <= 1'b1;
    end else if (seq_write_clear) begin
      tx_complete_flag_reg <= 1'b0;
    end else if (status_wr && zero_clear(reg_wdata_in, USF_TX_DONE_BIT)) begin
      tx_complete_flag_reg <= 1'b0;
    end
  end

  // rx not empty: cleared by any data access or by writing zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_not_empty_reg <= 1'b0;
    end else if (rx_accept) begin
      rx_not_empty_reg <= 1'b1;
    end else if (data_rd || data_wr) begin
      rx_not_empty_reg <= 1'b0;
    end else if (status_wr && zero_clear(reg_wdata_in, USF_RX_FULL_BIT)) begin
      rx_not_empty_reg <= 1'b0;
    end
  end

  // idle flag, cleared by status read then data read
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      idle_flag_reg <= 1'b0;
    end else if (idle_set) begin
      idle_flag_reg <= 1'b1;
    end else if (seq_read_clear) begin
      idle_flag_reg <= 1'b0;
    end
  end

  // one idle report per burst: rearmed by the next accepted word
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      idle_armed_reg <= 1'b1;
    end else if (rx_accept) begin
      idle_armed_reg <= 1'b1;
    end else if (idle_set) begin
      idle_armed_reg <= 1'b0;
    end
  end

  // overrun, cleared by the read sequence like the other errors
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      overrun_flag_reg <= 1'b0;
    end else if (rx_overrun) begin
      overrun_flag_reg <= 1'b1;
    end else if (seq_read_clear) begin
      overrun_flag_reg <= 1'b0;
    end
  end

  // noise flag
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      noise_flag_reg <= 1'b0;
    end else if (rx_word_valid_in && rx_noise_in) begin
      noise_flag_reg <= 1'b1;
    end else if (seq_read_clear) begin
      noise_flag_reg <= 1'b0;
    end
  end

  // framing error flag
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      framing_error_flag_reg <= 1'b0;
    end else if (rx_word_valid_in && rx_frame_err_in) begin
      framing_error_flag_reg <= 1'b1;
    end else if (seq_read_clear) begin
      framing_error_flag_reg <= 1'b0;
    end
  end

  // parity error only counts while receiving
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      parity_error_flag_reg <= 1'b0;
    end else if (receiver_enable && rx_word_valid_in && rx_parity_err_in) begin
      parity_error_flag_reg <= 1'b1;
    end else if (seq_read_clear) begin
      parity_error_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // holding registers behind the one data address

  logic [DATA_W-1:0] rx_holding_register;
  logic [DATA_W-1:0] tx_holding_register;

  // receive side keeps the unread word when an overrun hits
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rx_holding_register <= DATA_W'(USF_DATA_RST);
    end else if (rx_accept) begin
      rx_holding_register <= rx_word_in;
    end
  end

  // transmit side loaded by software writes
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_holding_register <= DATA_W'(USF_DATA_RST);
    end else if (data_wr) begin
      tx_holding_register <= reg_wdata_in[DATA_W-1:0];
    end
  end

  // handover pulse and word to the shifter
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tx_load_out <= 1'b0;
      tx_data_out <= DATA_W'(USF_DATA_RST);
    end else begin
      tx_load_out <= tx_handover;
      if (tx_handover) begin
        tx_data_out <= tx_holding_register;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  logic [USF_STATUS_W-1:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[USF_PARITY_BIT] = parity_error_flag_reg;
    status_word[USF_FRAMING_BIT] = framing_error_flag_reg;
    status_word[USF_NOISE_BIT] = noise_flag_reg;
    status_word[USF_OVERRUN_BIT] = overrun_flag_reg;
    status_word[USF_IDLE_BIT] = idle_flag_reg;
    status_word[USF_RX_FULL_BIT] = rx_not_empty_reg;
    status_word[USF_TX_DONE_BIT] = tx_complete_flag_reg;
    status_word[USF_TX_EMPTY_BIT] = tx_holding_empty_reg;
    status_word[USF_BREAK_BIT] = line_break_flag_reg;
    status_word[USF_CTS_BIT] = cts_flag_reg;
  end

  // registered read: values as they stood at the strobe; reserved and
  // unmapped bits read zero
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (status_rd) begin
      reg_rdata_out <= 32'(status_word);
    end else if (data_rd) begin
      reg_rdata_out <= 32'(rx_holding_register);
    end else if (ctrl_rd) begin
      reg_rdata_out <= 32'(ctrl_reg);
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request

  logic irq_any;
  logic err_gate;

  // noise and framing flags only reach the request in multibuffer mode
  assign err_gate = multibuffer_mode && error_irq_enable;

  always_comb begin
    irq_any = 1'b0;
    irq_any = irq_any || (cts_flag_reg && handshake_change_irq_enable);
    irq_any = irq_any || (line_break_flag_reg && line_break_irq_enable);
    irq_any = irq_any || (tx_holding_empty_reg && tx_holding_empty_irq_enable);
    irq_any = irq_any || (tx_complete_flag_reg && tx_complete_irq_enable);
    irq_any = irq_any || (rx_not_empty_reg && rx_not_empty_irq_enable);
    irq_any = irq_any || (overrun_flag_reg && rx_not_empty_irq_enable);
    irq_any = irq_any || (idle_flag_reg && idle_line_irq_enable);
    irq_any = irq_any || (parity_error_flag_reg && parity_irq_enable);
    irq_any = irq_any || (overrun_flag_reg && err_gate);
    irq_any = irq_any || (noise_flag_reg && err_gate);
    irq_any = irq_any || (framing_error_flag_reg && err_gate);
  end

  // registered so the request is glitch free; one cycle behind flags
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_any;
    end
  end

endmodule : usf_status_flags

// File: usf_status_flags_monitor.sv
`timescale 1ns/1ns
module usf_status_monitor
  import usf_pkg::*;
#(
  parameter int DATA_W = USF_DATA_W
) (
  input wire logic core_clk_in, // clock
  input wire logic sys_rst_in, // reset
  input wire logic [7:0] reg_addr_in, // address
  input wire logic [31:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  input wire logic [31:0] reg_rdata_out, // read data
  input wire logic clear_to_send_input_n_in, // modem pin
  input wire logic tx_shift_ready_in, // shifter free
  input wire logic tx_frame_done_in, // frame sent
  input wire logic tx_load_out, // handover
  input wire logic [DATA_W-1:0] tx_data_out, // handed word
  input wire logic rx_word_valid_in, // word done
  input wire logic [DATA_W-1:0] rx_word_in, // word
  input wire logic rx_noise_in, // noise
  input wire logic rx_frame_err_in, // framing
  input wire logic rx_parity_err_in, // parity
  input wire logic rx_idle_in, // idle
  input wire logic line_break_in, // break
  input wire logic irq_out // interrupt
);
  logic data_wr;
  logic rd_stat;
  logic pend_reg;
  logic [DATA_W-1:0] last_reg;
  assign data_wr = reg_wr_in && (reg_addr_in == USF_DATA_OFS);
  assign rd_stat = reg_rd_in && (reg_addr_in == USF_STATUS_OFS);
  ////////////////////////////////////////
  // last written word, pending until the shifter takes it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      pend_reg <= 1'b0;
      last_reg <= '0;
    end else if (data_wr) begin
      pend_reg <= 1'b1;
      last_reg <= reg_wdata_in[DATA_W-1:0];
    end else if (tx_load_out) begin
      pend_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////
  default clocking mon_cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_write_stalled;
    data_wr && !tx_shift_ready_in ##1 tx_shift_ready_in;
  endsequence
  sequence s_load_then_status;
    tx_load_out ##1 rd_stat;
  endsequence
  rd_idle_zero_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside read cycle");
  status_upper_a: assert property (rd_stat |=> reg_rdata_out[31:10] == 22'h0)
    else $error("reserved status bits not zero");
  data_upper_a: assert property (
    reg_rd_in && reg_addr_in == USF_DATA_OFS |=> reg_rdata_out[31:9] == 23'h0)
    else $error("data read upper bits not zero");
  load_needs_ready_a: assert property (tx_load_out |-> $past(tx_shift_ready_in))
    else $error("handover while shifter busy");
  load_single_a: assert property (tx_load_out |=> !tx_load_out)
    else $error("handover longer than one cycle");
  load_after_write_a: assert property (s_write_stalled |=> tx_load_out)
    else $error("written word not handed over");
  load_data_a: assert property (tx_load_out |-> tx_data_out == last_reg)
    else $error("handed word differs from written word");
  load_pending_a: assert property (tx_load_out |-> pend_reg)
    else $error("handover without a written word");
  empty_after_load_a: assert property (
    s_load_then_status |=> reg_rdata_out[USF_TX_EMPTY_BIT])
    else $error("tx empty not set after handover");
endmodule : usf_status_monitor

bind usf_status_flags usf_status_monitor #(.DATA_W(DATA_W)) usf_status_monitor_i (
  .core_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .clear_to_send_input_n_in, .tx_shift_ready_in, .tx_frame_done_in,
  .tx_load_out, .tx_data_out, .rx_word_valid_in, .rx_word_in, .rx_noise_in,
  .rx_frame_err_in, .rx_parity_err_in, .rx_idle_in, .line_break_in, .irq_out
);

// File: usf_status_flags_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top
  import usf_pkg::*;
();
  localparam logic [7:0] ST = USF_STATUS_OFS;
  localparam logic [7:0] DT = USF_DATA_OFS;
  logic clk, rst, wr_s, rd_s, stall, cts_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  wire logic [31:0] rdata;
  wire logic tx_ready, frame_done, load, irq, rx_valid, idle, brk;
  wire logic [8:0] tx_data, rx_word;
  wire logic [2:0] errs;
  int n_errors, tests_run;
  always #50 clk = ~clk;
  usf_status_flags usf_status_flags_i (.core_clk_in(clk), .sys_rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
    .reg_rdata_out(rdata), .clear_to_send_input_n_in(cts_n), .tx_shift_ready_in(tx_ready),
    .tx_frame_done_in(frame_done), .tx_load_out(load), .tx_data_out(tx_data),
    .rx_word_valid_in(rx_valid), .rx_word_in(rx_word), .rx_noise_in(errs[2]),
    .rx_frame_err_in(errs[1]), .rx_parity_err_in(errs[0]), .rx_idle_in(idle),
    .line_break_in(brk), .irq_out(irq));
  usf_line_partner usf_line_partner_i (.core_clk_in(clk), .stall_in(stall),
    .tx_load_in(load), .tx_shift_ready_out(tx_ready), .tx_frame_done_out(frame_done),
    .rx_valid_out(rx_valid), .rx_word_out(rx_word), .rx_err_out(errs),
    .rx_idle_out(idle), .line_break_out(brk));
  ////////////////////////////////////////
  // bus cycles: strobes last one cycle, read data taken in the next
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask : rdc
  // interrupt is one cycle behind the flags, so allow two edges
  task irq_chk(input logic [31:0] c, input logic e);
    wr(USF_CTRL_OFS, c);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(irq, e)
  endtask : irq_chk
  task wait_for(input logic frame);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      if ((frame ? frame_done : load) === 1'b1) break;
    end
    `CHK(i < 40, 1'b1)
  endtask : wait_for
  task conclude();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  task t_reset();
    rdc(ST, 32'h0C0);
    rdc(USF_CTRL_OFS, 32'h0);
    wr(8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0);
    rdc(ST, 32'h0C0);
  endtask : t_reset
  task t_tx();
    @(posedge clk);
    stall <= 1'b1;
    wr(DT, 32'h1A5);
    rdc(ST, 32'h000);
    @(posedge clk);
    stall <= 1'b0;
    wait_for(1'b0);
    `CHK(tx_data, 9'h1A5)
    rdc(ST, 32'h080);
    wait_for(1'b1);
    rdc(ST, 32'h0C0);
    irq_chk(32'h010, 1'b1);
    wr(ST, 32'h3BF);
    rdc(ST, 32'h080);
    irq_chk(32'h010, 1'b0);
    irq_chk(32'h008, 1'b1);
  endtask : t_tx
  task t_rx();
    usf_line_partner_i.send(9'h0F3, 3'h0);
    rdc(ST, 32'h0A0);
    irq_chk(32'h020, 1'b1);
    usf_line_partner_i.send(9'h155, 3'h1);
    rdc(ST, 32'h0A8);
    irq_chk(32'h280, 1'b1);
    irq_chk(32'h080, 1'b0);
    rdc(ST, 32'h0A8);
    wr(ST, 32'h3DF);
    irq_chk(32'h020, 1'b1);
    rdc(DT, 32'h0F3);
    rdc(ST, 32'h080);
  endtask : t_rx
  task t_err();
    irq_chk(32'h400, 1'b0);
    usf_line_partner_i.send(9'h011, 3'h7);
    rdc(ST, 32'h0A7);
    irq_chk(32'h480, 1'b0);
    irq_chk(32'h680, 1'b1);
    irq_chk(32'h500, 1'b1);
    rdc(ST, 32'h0A7);
    rdc(DT, 32'h011);
    rdc(ST, 32'h080);
  endtask : t_err
  task t_idle();
    usf_line_partner_i.pulse_line(1'b0);
    rdc(ST, 32'h090);
    irq_chk(32'h040, 1'b1);
    rdc(DT, 32'h011);
    rdc(ST, 32'h080);
    usf_line_partner_i.pulse_line(1'b0);
    rdc(ST, 32'h080);
    usf_line_partner_i.send(9'h022, 3'h0);
    usf_line_partner_i.pulse_line(1'b0);
    rdc(ST, 32'h0B0);
    rdc(DT, 32'h022);
    rdc(ST, 32'h080);
  endtask : t_idle
  task t_break();
    usf_line_partner_i.pulse_line(1'b1);
    rdc(ST, 32'h180);
    irq_chk(32'h004, 1'b1);
    wr(ST, 32'h2FF);
    rdc(ST, 32'h080);
  endtask : t_break
  task t_cts();
    irq_chk(32'h001, 1'b0);
    @(posedge clk);
    cts_n <= 1'b0;
    repeat (6) @(posedge clk);
    rdc(ST, 32'h280);
    irq_chk(32'h003, 1'b1);
    wr(ST, 32'h0);
    rdc(ST, 32'h080);
  endtask : t_cts
  // write clears rx not empty; shifter frees up right after the write
  task t_rx_wr();
    usf_line_partner_i.send(9'h033, 3'h0);
    rdc(ST, 32'h0A0);
    @(posedge clk);
    stall <= 1'b1;
    wr(DT, 32'h044);
    stall <= 1'b0;
    wait_for(1'b0);
    rdc(ST, 32'h080);
  endtask : t_rx_wr
  ////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    stall = 1'b0;
    cts_n = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_idle();
    t_break();
    t_cts();
    t_rx_wr();
    conclude();
  end
endmodule : tb_top
